//--- logic/ots_pkg.sv
package ots_pkg;

   // ==========================================================
   // Register map, byte addresses on the Wishbone slave.
   localparam logic [4:0] OTS_ADR_T1_SEL = 5'h00;
   localparam logic [4:0] OTS_ADR_T2_SEL = 5'h04;
   localparam logic [4:0] OTS_ADR_RELAY_SEL = 5'h08;
   localparam logic [4:0] OTS_ADR_REMOTE = 5'h0C;
   localparam logic [4:0] OTS_ADR_MAINT_CNT = 5'h10;
   localparam logic [4:0] OTS_ADR_MAINT_THR = 5'h14;
   localparam logic [4:0] OTS_ADR_CTRL = 5'h18;
   localparam logic [4:0] OTS_ADR_STATUS = 5'h1C;

   // ==========================================================
   // Setting codes and their polarity split.
   localparam logic [7:0] OTS_NEG_OFFSET = 8'h64;
   localparam logic [7:0] OTS_CODE_LIMIT = 8'hC8;
   localparam logic [7:0] OTS_C_RUNNING = 8'h00;
   localparam logic [7:0] OTS_C_FREQ_REACHED = 8'h01;
   localparam logic [7:0] OTS_C_FREQ_DETECT = 8'h04;
   localparam logic [7:0] OTS_C_READY = 8'h0B;
   localparam logic [7:0] OTS_C_SAFE_MON = 8'h50;
   localparam logic [7:0] OTS_C_SAFE_HEALTHY = 8'h51;
   localparam logic [7:0] OTS_C_LIFE = 8'h5A;
   localparam logic [7:0] OTS_C_POWER_OFF = 8'h5B;
   localparam logic [7:0] OTS_C_AVG_PULSE = 8'h5D;
   localparam logic [7:0] OTS_C_MAINT = 8'h5F;
   localparam logic [7:0] OTS_C_REMOTE = 8'h60;
   localparam logic [7:0] OTS_C_MINOR = 8'h62;
   localparam logic [7:0] OTS_C_TRIP = 8'h63;

   // ==========================================================
   // Values after reset.
   localparam logic [7:0] OTS_RST_T1_SEL = 8'h00;
   localparam logic [7:0] OTS_RST_T2_SEL = 8'h04;
   localparam logic [7:0] OTS_RST_RELAY_SEL = 8'h63;
   localparam logic [15:0] OTS_RST_MAINT_THR = 16'hFFFF;

   // ==========================================================
   // Control and status bit positions.
   localparam int OTS_CTRL_FAULT_RESET = 0;
   localparam int OTS_ST_TERM = 0;
   localparam int OTS_ST_TRIP = 3;
   localparam int OTS_ST_READY = 4;
   localparam int OTS_ST_RUN = 5;
   localparam int OTS_ST_MAINT = 6;
   localparam int OTS_ST_REJECT = 7;

   // ==========================================================
   // Pulse monitor slot length in clock cycles.
   localparam int OTS_CLK_HZ = 25_000_000;
   localparam int OTS_SLOT_US = 1000;
   localparam int OTS_SLOT_CYCLES = OTS_CLK_HZ / 1_000_000 * OTS_SLOT_US;

   typedef enum logic [4:0] {
      OTS_PS_START = 5'b00001,
      OTS_PS_GAP1 = 5'b00010,
      OTS_PS_CURRENT = 5'b00100,
      OTS_PS_GAP2 = 5'b01000,
      OTS_PS_MAINT = 5'b10000
   } ots_pulse_state_e;

endpackage

//--- logic/ots_avg_pulse.sv
`timescale 1ns/1ps
module ots_avg_pulse #(
   parameter int VAL_W = 8,
   parameter int SLOT_CYCLES = ots_pkg::OTS_SLOT_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [VAL_W-1:0] current_i,
   input wire logic [VAL_W-1:0] maint_i,
   output logic pulse_o
);
   import ots_pkg::*;

   if (VAL_W < 1 || VAL_W > 16 || SLOT_CYCLES < 1) begin
      $error("ots_avg_pulse: unsupported parameters");
   end

   // ==========================================================
   // Slot divider: one enable pulse per slot.
   logic [31:0] div_q;
   logic slot_en;
   assign slot_en = (div_q == 32'(SLOT_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || slot_en) begin
         div_q <= 32'h0000_0000;
      end else begin
         div_q <= div_q + 32'h0000_0001;
      end
   end

   // ==========================================================
   // Frame: start mark, gap, current width, gap, timer width.
   // Widths are sampled at frame start so a frame stays coherent.
   ots_pulse_state_e st_q;
   logic [VAL_W:0] left_q;
   logic [VAL_W-1:0] maint_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= OTS_PS_START;
         left_q <= '0;
         maint_q <= '0;
         pulse_o <= 1'b0;
      end else if (slot_en) begin
         unique case (st_q)
            OTS_PS_START: begin
               pulse_o <= 1'b1;
               maint_q <= maint_i;
               left_q <= {1'b0, current_i} + 1'b1;
               st_q <= OTS_PS_GAP1;
            end
            OTS_PS_GAP1: begin
               pulse_o <= 1'b0;
               st_q <= OTS_PS_CURRENT;
            end
            OTS_PS_CURRENT: begin
               pulse_o <= (left_q > 1);
               left_q <= left_q - 1'b1;
               if (left_q <= 1) begin
                  left_q <= {1'b0, maint_q} + 1'b1;
                  st_q <= OTS_PS_GAP2;
               end
            end
            OTS_PS_GAP2: begin
               pulse_o <= 1'b0;
               st_q <= OTS_PS_MAINT;
            end
            OTS_PS_MAINT: begin
               pulse_o <= (left_q > 1);
               left_q <= left_q - 1'b1;
               if (left_q <= 1) begin
                  st_q <= OTS_PS_START;
               end
            end
         endcase
      end
   end
endmodule

//--- logic/ots_terminal_select.sv
`timescale 1ns/1ps
module ots_terminal_select #(
   parameter bit SAFETY_MODEL = 1'b1,
   parameter int PULSE_W = 8,
   parameter int SLOT_CYCLES = ots_pkg::OTS_SLOT_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Drive status inputs.
   input wire logic drive_resetting_i,
   input wire logic freq_at_start_i,
   input wire logic dc_brake_i,
   input wire logic start_cmd_i,
   input wire logic frequency_reached_flag_i,
   input wire logic freq_detect_i,
   input wire logic output_stop_input_i,
   input wire logic safety_stop_i,
   input wire logic [3:0] safety_fault_i,
   input wire logic [3:0] life_end_i,
   input wire logic [6:0] power_off_src_i,
   input wire logic trip_i,
   input wire logic fault_reset_i,
   input wire logic coasting_i,
   input wire logic power_loss_i,
   input wire logic fan_fail_i,
   input wire logic comm_warn_i,
   input wire logic maint_tick_i,
   input wire logic [PULSE_W-1:0] avg_current_i,
   // Terminal drive, high while the terminal conducts.
   output logic term1_on_o,
   output logic term2_on_o,
   output logic relay_on_o
);
   import ots_pkg::*;

   if (PULSE_W < 1 || PULSE_W > 16) begin
      $error("ots_terminal_select: PULSE_W out of range");
   end

   // ==========================================================
   // Code decoding helpers.

   // Splits a setting code into base code and negative polarity.
   function automatic logic [7:0] base_of(input logic [7:0] code);
      if (code >= OTS_NEG_OFFSET) begin
         return 8'(code - OTS_NEG_OFFSET);
      end
      return code;
   endfunction

   function automatic logic neg_of(input logic [7:0] code);
      return (code >= OTS_NEG_OFFSET);
   endfunction

   // Decides whether a selector may take a code.
   function automatic logic code_ok(input logic [7:0] code,
                                    input logic is_relay);
      logic [7:0] b;
      logic ok;
      b = base_of(code);
      ok = 1'b0;
      if (code < OTS_CODE_LIMIT) begin
         unique case (b)
            OTS_C_RUNNING, OTS_C_FREQ_REACHED, OTS_C_FREQ_DETECT,
            OTS_C_READY, OTS_C_LIFE, OTS_C_POWER_OFF, OTS_C_MAINT,
            OTS_C_REMOTE, OTS_C_MINOR, OTS_C_TRIP: ok = 1'b1;
            OTS_C_SAFE_MON, OTS_C_SAFE_HEALTHY: ok = SAFETY_MODEL;
            OTS_C_AVG_PULSE: ok = !is_relay;
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   // Merges a write into a 16-bit field under the byte lanes.
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = wdat[15:8];
      end
      return r;
   endfunction

   // ==========================================================
   // Wishbone handshake: one wait state, ack drops after one cycle.
   logic req;
   logic wr;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // ==========================================================
   // Selector registers. A refused code leaves the old setting.
   logic [7:0] sel_q [3];
   logic reject_q;
   logic [1:0] wr_idx;
   logic wr_sel;
   logic [2:0] remote_q;

   always_comb begin
      wr_idx = 2'd0;
      wr_sel = 1'b0;
      unique case (wb_adr_i)
         OTS_ADR_T1_SEL: begin
            wr_idx = 2'd0;
            wr_sel = wr && wb_sel_i[0];
         end
         OTS_ADR_T2_SEL: begin
            wr_idx = 2'd1;
            wr_sel = wr && wb_sel_i[0];
         end
         OTS_ADR_RELAY_SEL: begin
            wr_idx = 2'd2;
            wr_sel = wr && wb_sel_i[0];
         end
         default: wr_sel = 1'b0;
      endcase
   end

   // Reset defaults put running on terminal one and trip on the relay.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_q[0] <= OTS_RST_T1_SEL;
         sel_q[1] <= OTS_RST_T2_SEL;
         sel_q[2] <= OTS_RST_RELAY_SEL;
         reject_q <= 1'b0;
      end else if (wr_sel) begin
         if (code_ok(wb_dat_i[7:0], wr_idx == 2'd2)) begin
            sel_q[wr_idx] <= wb_dat_i[7:0];
            reject_q <= 1'b0;
         end else begin
            reject_q <= 1'b1;
         end
      end
   end

   // Remote output bits, one per terminal.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         remote_q <= 3'b000;
      end else if (wr && wb_sel_i[0] && wb_adr_i == OTS_ADR_REMOTE) begin
         remote_q <= wb_dat_i[2:0];
      end
   end

   // ==========================================================
   // Maintenance count and threshold. The tick wins over a write
   // arriving in the same cycle only by adding to the written value.
   logic [15:0] maint_cnt_q;
   logic [15:0] maint_thr_q;
   logic [15:0] cnt_base;
   logic maint_flag;

   assign cnt_base = (wr && wb_adr_i == OTS_ADR_MAINT_CNT)
      ? merge16(maint_cnt_q, wb_dat_i, wb_sel_i) : maint_cnt_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         maint_cnt_q <= 16'h0000;
      end else if (maint_tick_i && cnt_base != 16'hFFFF) begin
         maint_cnt_q <= cnt_base + 16'h0001;
      end else begin
         maint_cnt_q <= cnt_base;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         maint_thr_q <= OTS_RST_MAINT_THR;
      end else if (wr && wb_adr_i == OTS_ADR_MAINT_THR) begin
         maint_thr_q <= merge16(maint_thr_q, wb_dat_i, wb_sel_i);
      end
   end

   assign maint_flag = (maint_cnt_q >= maint_thr_q);

   // ==========================================================
   // Trip flag: held until a fault reset. A trip in the reset cycle
   // keeps the flag set, so no trip is ever lost.
   logic trip_fault_flag_q;
   logic fault_clr;
   assign fault_clr = fault_reset_i ||
      (wr && wb_sel_i[0] && wb_adr_i == OTS_ADR_CTRL &&
       wb_dat_i[OTS_CTRL_FAULT_RESET]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trip_fault_flag_q <= 1'b0;
      end else if (trip_i) begin
         trip_fault_flag_q <= 1'b1;
      end else if (fault_clr) begin
         trip_fault_flag_q <= 1'b0;
      end
   end

   // ==========================================================
   // Status conditions.
   logic shutoff;
   logic operation_ready_flag;
   logic running;
   logic safety_circuit_healthy;
   logic life_alarm;
   logic power_off_fault;
   logic minor_alarm;
   logic avg_current_pulse_out;

   // Shutoff covers a held fault, the output-stop input and safety stop.
   assign shutoff = trip_fault_flag_q || output_stop_input_i ||
      safety_stop_i;

   // Ready survives coasting or power loss alone, but not coasting during power loss.
   assign operation_ready_flag = !drive_resetting_i && !shutoff &&
      !(coasting_i && power_loss_i);

   // Coasting forces running low even though ready may stay on.
   assign running = freq_at_start_i && start_cmd_i && !dc_brake_i &&
      !coasting_i && !drive_resetting_i && !shutoff;

   assign safety_circuit_healthy = ~|safety_fault_i;
   assign life_alarm = |life_end_i;
   assign power_off_fault = |power_off_src_i;
   assign minor_alarm = fan_fail_i || comm_warn_i;

   // The pulse monitor samples the low bits of the maintenance count.
   ots_avg_pulse #(
      .VAL_W(PULSE_W),
      .SLOT_CYCLES(SLOT_CYCLES)
   ) u_pulse (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .current_i(avg_current_i),
      .maint_i(maint_cnt_q[PULSE_W-1:0]),
      .pulse_o(avg_current_pulse_out)
   );

   // Picks the condition for one selector code.
   function automatic logic pick(input logic [7:0] code,
                                 input logic remote);
      logic c;
      c = 1'b0;
      unique case (base_of(code))
         OTS_C_RUNNING: c = running;
         OTS_C_FREQ_REACHED: c = frequency_reached_flag_i;
         OTS_C_FREQ_DETECT: c = freq_detect_i;
         OTS_C_READY: c = operation_ready_flag;
         OTS_C_SAFE_MON: c = safety_stop_i;
         OTS_C_SAFE_HEALTHY: c = safety_circuit_healthy;
         OTS_C_LIFE: c = life_alarm;
         OTS_C_POWER_OFF: c = power_off_fault;
         OTS_C_AVG_PULSE: c = avg_current_pulse_out;
         OTS_C_MAINT: c = maint_flag;
         OTS_C_REMOTE: c = remote;
         OTS_C_MINOR: c = minor_alarm;
         OTS_C_TRIP: c = trip_fault_flag_q;
         default: c = 1'b0;
      endcase
      return c;
   endfunction

   // ==========================================================
   // Terminal outputs. Each selector decodes on its own, so one
   // condition may sit on several terminals at once.
   logic [2:0] term_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         term_q <= 3'b000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            term_q[i] <= pick(sel_q[i], remote_q[i]) ^
               neg_of(sel_q[i]);
         end
      end
   end

   assign term1_on_o = term_q[0];
   assign term2_on_o = term_q[1];
   assign relay_on_o = term_q[2];

   // ==========================================================
   // Read data, registered with the ack; unmapped reads give zero.
   logic [31:0] status_w;
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[OTS_ST_TERM +: 3] = term_q;
      status_w[OTS_ST_TRIP] = trip_fault_flag_q;
      status_w[OTS_ST_READY] = operation_ready_flag;
      status_w[OTS_ST_RUN] = running;
      status_w[OTS_ST_MAINT] = maint_flag;
      status_w[OTS_ST_REJECT] = reject_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            OTS_ADR_T1_SEL: wb_dat_o <= {24'h00_0000, sel_q[0]};
            OTS_ADR_T2_SEL: wb_dat_o <= {24'h00_0000, sel_q[1]};
            OTS_ADR_RELAY_SEL: wb_dat_o <= {24'h00_0000, sel_q[2]};
            OTS_ADR_REMOTE: wb_dat_o <= {29'h0000_0000, remote_q};
            OTS_ADR_MAINT_CNT: wb_dat_o <= {16'h0000, maint_cnt_q};
            OTS_ADR_MAINT_THR: wb_dat_o <= {16'h0000, maint_thr_q};
            OTS_ADR_STATUS: wb_dat_o <= status_w;
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule

//--- sim/ots_term_reader.sv
`timescale 1ns/1ps
module ots_term_reader (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic term1_on_i,
   input wire logic relay_on_i,
   input wire logic clr_i,
   output logic [15:0] max_hi_o,
   output logic [15:0] relay_flips_o
);
   // ==========================================================
   // Times conducting runs and counts contact flips.
   logic [15:0] run_q;
   logic relay_q;

   // Longest conducting run seen on terminal one, in clock cycles.
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         run_q <= 16'h0000;
         max_hi_o <= 16'h0000;
      end else begin
         run_q <= term1_on_i ? run_q + 16'h0001 : 16'h0000;
         if (!term1_on_i && run_q > max_hi_o) begin
            max_hi_o <= run_q;
         end
      end
   end

   // Contact wear grows with every flip, so the relay is counted.
   always_ff @(posedge clk_i) begin
      relay_q <= relay_on_i;
      if (rst_i) begin
         relay_flips_o <= 16'h0000;
      end else if (relay_on_i != relay_q) begin
         relay_flips_o <= relay_flips_o + 16'h0001;
      end
   end
endmodule

//--- sim/ots_chk_sva.sv
`timescale 1ns/1ps
module ots_chk
   import ots_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic drive_resetting_i,
   input wire logic [3:0] safety_fault_i,
   input wire logic [3:0] life_end_i,
   input wire logic trip_i,
   input wire logic fault_reset_i,
   input wire logic fan_fail_i,
   input wire logic comm_warn_i,
   input wire logic term1_on_o,
   input wire logic term2_on_o,
   input wire logic relay_on_o
);
   // ==========================================================
   // Shadow of the selectors; refused codes must leave them alone.
   logic [7:0] sh_q [3];
   logic sel_wr;

   function automatic logic code_ok(input logic [7:0] c, input logic r);
      logic [7:0] b;
      b = (c >= OTS_NEG_OFFSET) ? c - OTS_NEG_OFFSET : c;
      return (c < OTS_CODE_LIMIT) && ((b == OTS_C_AVG_PULSE) ? !r :
         (b inside {OTS_C_RUNNING, OTS_C_FREQ_REACHED, OTS_C_FREQ_DETECT,
         OTS_C_READY, OTS_C_SAFE_MON, OTS_C_SAFE_HEALTHY, OTS_C_LIFE,
         OTS_C_POWER_OFF, OTS_C_MAINT, OTS_C_REMOTE, OTS_C_MINOR,
         OTS_C_TRIP}));
   endfunction

   // A selector write lands at the edge where ack is sampled.
   assign sel_wr = wb_ack_o && wb_we_i && wb_sel_i[0] &&
      wb_adr_i < 5'h0C && wb_adr_i[1:0] == 2'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_q[0] <= OTS_RST_T1_SEL;
         sh_q[1] <= OTS_RST_T2_SEL;
         sh_q[2] <= OTS_RST_RELAY_SEL;
      end else if (sel_wr && code_ok(wb_dat_i[7:0], wb_adr_i[3])) begin
         sh_q[wb_adr_i[3:2]] <= wb_dat_i[7:0];
      end
   end

   // ==========================================================
   // Properties.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not answered next cycle");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   trip_set_a: assert property (sh_q[2] == OTS_C_TRIP && trip_i &&
      !wb_cyc_i |-> ##2 relay_on_o) else $error("trip not on relay");
   trip_hold_a: assert property ((sh_q[2] == OTS_C_TRIP &&
      !fault_reset_i && !wb_cyc_i)[*2] ##0 relay_on_o |=> relay_on_o)
      else $error("trip flag dropped without reset");
   safe_ok_a: assert property ((sh_q[0] == OTS_C_SAFE_HEALTHY &&
      safety_fault_i != 4'h0)[*3] |-> !term1_on_o)
      else $error("healthy shown despite safety fault");
   life_on_a: assert property ((sh_q[0] == OTS_C_LIFE &&
      life_end_i != 4'h0)[*3] |-> term1_on_o)
      else $error("life alarm not shown");
   minor_neg_a: assert property (((fan_fail_i || comm_warn_i) &&
      sh_q[1] == OTS_C_MINOR + OTS_NEG_OFFSET)[*3] |-> !term2_on_o)
      else $error("negative alarm still conducts");
   ready_reset_a: assert property ((sh_q[2] == OTS_C_READY &&
      drive_resetting_i)[*3] |-> !relay_on_o)
      else $error("ready shown while resetting");

   cover property (sh_q[2] == OTS_C_TRIP && relay_on_o);
   cover property (wb_ack_o && !wb_we_i);
   cover property (wb_ack_o && wb_adr_i[1:0] != 2'h0);
endmodule

bind ots_terminal_select ots_chk ots_chk_inst (.*);

//--- sim/tb_output_terminal_function_select.sv
`timescale 1ns/1ps
module tb_output_terminal_function_select;
   import ots_pkg::*;
   localparam int SLOT = 2;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, clr;
   logic [4:0] wb_adr_i;
   logic [3:0] wb_sel_i, safety_fault_i, life_end_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic drive_resetting_i, freq_at_start_i, dc_brake_i, start_cmd_i;
   logic frequency_reached_flag_i, freq_detect_i, output_stop_input_i;
   logic safety_stop_i, trip_i, fault_reset_i, coasting_i, power_loss_i;
   logic fan_fail_i, comm_warn_i, maint_tick_i;
   logic term1_on_o, term2_on_o, relay_on_o;
   logic [6:0] power_off_src_i;
   logic [7:0] avg_current_i;
   logic [15:0] max_hi, flips;
   int err_total, n_tests, cyc_n;

   ots_terminal_select #(.SLOT_CYCLES(SLOT)) ots_terminal_select_inst (.*);

   ots_term_reader ots_term_reader_inst (.clk_i, .rst_i,
      .term1_on_i(term1_on_o), .relay_on_i(relay_on_o), .clr_i(clr),
      .max_hi_o(max_hi), .relay_flips_o(flips));

   // ==========================================================
   // Clock, and a run limit far above the run's length.
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   // ==========================================================
   // Shared helpers.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic chk(input logic [31:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: got %0h exp %0h", $time, m, got, exp);
      end
   endtask

   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic we, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wsel(input logic [4:0] a, input logic [7:0] c);
      wb(1'b1, a, {24'h00_0000, c}, rd);
   endtask

   task automatic cond(input int i, input logic v);
      case (i)
         0: safety_stop_i <= v;
         1: safety_fault_i <= v ? 4'h0 : 4'h2;
         2: life_end_i <= v ? 4'h8 : 4'h0;
         3: power_off_src_i <= v ? 7'h40 : 7'h00;
         4: fan_fail_i <= v;
         5: frequency_reached_flag_i <= v;
         6: freq_detect_i <= v;
         default: comm_warn_i <= v;
      endcase
   endtask

   // ==========================================================
   // Scenarios.
   task automatic t_defaults();
      logic [4:0] a [4] = '{OTS_ADR_T1_SEL, OTS_ADR_T2_SEL,
         OTS_ADR_RELAY_SEL, OTS_ADR_MAINT_THR};
      logic [31:0] e [4] = '{32'(OTS_RST_T1_SEL), 32'(OTS_RST_T2_SEL),
         32'(OTS_RST_RELAY_SEL), 32'(OTS_RST_MAINT_THR)};
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, a[i], 32'h0000_0000, rd);
         chk(rd, e[i], "reset selector");
      end
      wb(1'b0, 5'h02, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000, "unmapped read");
   endtask

   task automatic t_trip();
      wsel(OTS_ADR_T1_SEL, OTS_C_TRIP);
      trip_i <= 1'b1;
      tick(1);
      trip_i <= 1'b0;
      tick(8);
      chk(relay_on_o, 1'b1, "trip on relay");
      chk(term1_on_o, 1'b1, "trip on term1");
      wb(1'b0, OTS_ADR_STATUS, 32'h0000_0000, rd);
      chk(rd[OTS_ST_TRIP], 1'b1, "trip status");
      fault_reset_i <= 1'b1;
      tick(1);
      fault_reset_i <= 1'b0;
      tick(3);
      chk(relay_on_o, 1'b0, "fault reset");
      trip_i <= 1'b1;
      tick(1);
      trip_i <= 1'b0;
      wb(1'b1, OTS_ADR_CTRL, 32'h0000_0001, rd);
      tick(3);
      chk(relay_on_o, 1'b0, "soft fault reset");
   endtask

   // Positive on term1 and negative on term2, same condition.
   task automatic t_polarity();
      logic v;
      logic [7:0] c [8] = '{OTS_C_SAFE_MON, OTS_C_SAFE_HEALTHY, OTS_C_LIFE,
         OTS_C_POWER_OFF, OTS_C_MINOR, OTS_C_FREQ_REACHED,
         OTS_C_FREQ_DETECT, OTS_C_MINOR};
      for (int i = 0; i < 8; i++) begin
         wsel(OTS_ADR_T1_SEL, c[i]);
         wsel(OTS_ADR_T2_SEL, c[i] + OTS_NEG_OFFSET);
         for (int k = 0; k < 2; k++) begin
            v = (k == 0);
            cond(i, v);
            tick(4);
            chk(term1_on_o, v, "positive code");
            chk(term2_on_o, !v, "negative code");
         end
      end
      safety_fault_i <= 4'h0;
   endtask

   task automatic t_reject();
      wsel(OTS_ADR_RELAY_SEL, OTS_C_AVG_PULSE);
      wb(1'b0, OTS_ADR_STATUS, 32'h0000_0000, rd);
      chk(rd[OTS_ST_REJECT], 1'b1, "relay pulse refused");
      wb(1'b0, OTS_ADR_RELAY_SEL, 32'h0000_0000, rd);
      chk(rd, 32'(OTS_C_TRIP), "relay code kept");
      wsel(OTS_ADR_T2_SEL, 8'hC8);
      wb(1'b0, OTS_ADR_T2_SEL, 32'h0000_0000, rd);
      chk(rd, 32'h0000_00C6, "code 200 refused");
      wsel(OTS_ADR_T1_SEL, OTS_C_AVG_PULSE);
      wb(1'b0, OTS_ADR_STATUS, 32'h0000_0000, rd);
      chk(rd[OTS_ST_REJECT], 1'b0, "term1 pulse taken");
      for (int n = 3; n < 7; n += 2) begin
         avg_current_i <= 8'(n);
         clr <= 1'b1;
         tick(1);
         clr <= 1'b0;
         tick(80);
         chk(32'(max_hi), 32'(n * SLOT), "current pulse width");
      end
   endtask

   // Rows: [8] ready, [7] running, then reset, run request, brake,
   // output stop, coasting, power loss, safety stop.
   task automatic t_ready_run();
      logic [8:0] t [8] = '{9'h040, 9'h100, 9'h1A0, 9'h130, 9'h028,
         9'h124, 9'h006, 9'h021};
      wsel(OTS_ADR_T1_SEL, OTS_C_RUNNING);
      wsel(OTS_ADR_RELAY_SEL, OTS_C_READY);
      for (int i = 0; i < 8; i++) begin
         {drive_resetting_i, start_cmd_i, dc_brake_i, output_stop_input_i,
            coasting_i, power_loss_i, safety_stop_i} <= t[i][6:0];
         freq_at_start_i <= t[i][5];
         tick(4);
         chk(relay_on_o, t[i][8], "ready");
         chk(term1_on_o, t[i][7], "running");
      end
      {start_cmd_i, freq_at_start_i, safety_stop_i} <= 3'h0;
   endtask

   task automatic t_remote_maint();
      wsel(OTS_ADR_T1_SEL, OTS_C_REMOTE);
      wsel(OTS_ADR_T2_SEL, OTS_C_REMOTE);
      wsel(OTS_ADR_RELAY_SEL, OTS_C_REMOTE);
      wb(1'b1, OTS_ADR_REMOTE, 32'h0000_0005, rd);
      tick(3);
      chk({29'h0, relay_on_o, term2_on_o, term1_on_o}, 32'h0000_0005,
         "remote bits");
      wsel(OTS_ADR_T2_SEL, OTS_C_MAINT);
      wb(1'b1, OTS_ADR_MAINT_THR, 32'h0000_0003, rd);
      wb(1'b1, OTS_ADR_MAINT_CNT, 32'h0000_0002, rd);
      tick(3);
      chk(term2_on_o, 1'b0, "below threshold");
      maint_tick_i <= 1'b1;
      tick(1);
      maint_tick_i <= 1'b0;
      tick(3);
      chk(term2_on_o, 1'b1, "threshold reached");
      chk(32'(flips < 16'h0020), 32'h0000_0001, "relay flips");
   endtask

   task automatic wrap_up();
      $display("mismatches %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence.
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {drive_resetting_i, freq_at_start_i, dc_brake_i, start_cmd_i} = '0;
      {frequency_reached_flag_i, freq_detect_i, output_stop_input_i} = '0;
      {safety_stop_i, safety_fault_i, life_end_i, power_off_src_i} = '0;
      {trip_i, fault_reset_i, coasting_i, power_loss_i, clr} = '0;
      {fan_fail_i, comm_warn_i, maint_tick_i, avg_current_i} = '0;
      {err_total, n_tests, cyc_n} = '0;
      rst_i = 1'b1;
      tick(3);
      rst_i <= 1'b0;
      t_defaults();
      t_trip();
      t_polarity();
      t_reject();
      t_ready_run();
      t_remote_maint();
      wrap_up();
   end
endmodule
